// file: fsr_pkg.sv
`default_nettype none
// ==========================================================
// Frame standard recognition constants
package fsr_pkg;

	// Clock and half-line tick
	localparam int CLK_MHZ         = 125;
	localparam int HALF_LINE_US    = 32;
	localparam int LINE_US         = 64;
	localparam int HALF_LINE_CYC   = HALF_LINE_US * CLK_MHZ;
	localparam int TICK_W          = 12;

	// Frame periods, in microseconds and in half-line ticks
	localparam int FRAME50_US      = 20000;
	localparam int FRAME60_US      = 16683;
	localparam int FREE_LONG_US    = 23000;
	localparam int POS_W           = 10;
	localparam logic [9:0] FRAME50_HL   = 10'(FRAME50_US / HALF_LINE_US);
	localparam logic [9:0] FRAME60_HL   = 10'(FRAME60_US / HALF_LINE_US);
	localparam logic [9:0] FREE_LONG_HL = 10'(FREE_LONG_US / HALF_LINE_US);

	// Window half widths and the wide window opening line
	localparam logic [9:0] REG_WIN_HALF = 10'h006;
	localparam logic [9:0] WIDE_LO_LINE = 10'h0fa;

	// Discharge pulse length in half-line ticks
	localparam logic [9:0] DISCH_HL     = 10'h002;

	// Shift register reset values
	localparam logic [1:0] SHR50_RST    = 2'h0;
	localparam logic [2:0] SHR60_RST    = 3'h0;

	// Half-line count of the instant labelled as line x
	function automatic logic [9:0] fsr_line_to_hl(input logic [9:0] x);
		logic [19:0] us;
		us = 20'(LINE_US) * 20'(x - 10'h001) + 20'(HALF_LINE_US);
		return 10'(us / 20'(HALF_LINE_US));
	endfunction

	// Inclusive range test on the half-line position
	function automatic logic fsr_in_range(input logic [9:0] pos,
		input logic [9:0] lo, input logic [9:0] hi);
		return (pos >= lo) && (pos <= hi);
	endfunction

endpackage
`default_nettype wire

// file: fsr_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Half-line tick generator
module fsr_tick_gen #(
	parameter int unsigned PERIOD = fsr_pkg::HALF_LINE_CYC
) (
	input  wire logic clk_sys, // System clock
	input  wire logic rst,     // Async reset, active high
	input  wire logic clear,   // Restart the half-line phase
	output logic      tick     // One pulse per half line
);
	import fsr_pkg::*;

	logic [TICK_W-1:0] cnt_r;
	logic [TICK_W-1:0] cnt_nxt;
	logic              tick_nxt;

	// Divider next state
	always_comb begin
		tick_nxt = 1'b0;
		if (clear) begin
			cnt_nxt = '0;
		end else if (cnt_r == TICK_W'(PERIOD - 1)) begin
			cnt_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	// Divider registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end

	// Ticks never come back to back
	a_tick_spacing: assert property (@(posedge clk_sys) disable iff (rst)
		tick |=> !tick [*3])
		else $error("half-line ticks too close");

endmodule // fsr_tick_gen
`default_nettype wire

// file: fsr_frame_logic.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Function
// - Frame logic runs from one accurate tick every half line, 32 us.
// - All frame periods and intervals come from counting half-line ticks.
// - Line x sits at 64 us times (x-1) plus 32 us after reset.
// - Two shift registers, one per standard, shifted at every frame end; ones come only from in-window pulses.
// - 50 Hz is identified only after two successive in-window pulses.
// - First pulse resets counters; second sets 50 Hz flag one frame later.
// - 50 Hz flag stays clear unless two successive in-window pulses seen.
// - 50 Hz flag narrows the vertical sync window.
// - 60 Hz is identified only after three successive 60 Hz pulses.
// - 60 Hz flag narrows window and sets free-run period on missing pulses.
// - 60 Hz recognition drives the extra slope current enable.
// - Sync acts only at end of scan, firing the sawtooth discharge.
// - The discharge output is driven only by this frame logic.
// - Window stays wide until a standard is identified, then narrows.
// - Without transmission, sync is ignored and frames free-run near 50 Hz.
// - Video-recorder mode keeps the sync window wide.
module fsr_frame_logic #(
	parameter int unsigned HALF_LINE_P = fsr_pkg::HALF_LINE_CYC // Clocks per half line
) (
	input  wire logic clk_sys,              // System clock, 125 MHz
	input  wire logic rst,                  // Async reset, active high
	input  wire logic sync_pulse,           // Frame sync, one cycle
	input  wire logic transmission_present, // High while a signal is received
	input  wire logic vcr_mode,             // Video-recorder mode
	output logic      sawtooth_discharge,   // Sawtooth discharge control
	output logic      fifty_hz_identified,  // 50 Hz standard identified
	output logic      sixty_hz_identified,  // 60 Hz standard identified
	output logic      slope_boost_enable,   // Extra slope current enable
	output logic      window_narrow         // Sync window reduced
);
	import fsr_pkg::*;

	// ==========================================================
	// Half-line tick
	logic tick;
	logic frame_end;

	fsr_tick_gen #(
		.PERIOD(HALF_LINE_P)
	) u_tick (
		.clk_sys(clk_sys),
		.rst    (rst),
		.clear  (frame_end),
		.tick   (tick)
	);

	// ==========================================================
	// Windows and frame end
	logic [9:0] pos_r;
	logic [9:0] pos_nxt;
	logic [1:0] shr50_r;
	logic [1:0] shr50_nxt;
	logic [2:0] shr60_r;
	logic [2:0] shr60_nxt;
	logic       fifty_nxt;
	logic       sixty_nxt;
	logic       narrow_nxt;
	logic       disch_nxt;
	logic       in_w50;
	logic       in_w60;
	logic       in_sync_win;
	logic       sync_accept;
	logic       hit50;
	logic       hit60;
	logic [9:0] free_limit;
	logic [9:0] w50_lo;
	logic [9:0] w50_hi;
	logic [9:0] w60_lo;
	logic [9:0] w60_hi;
	logic [9:0] wide_lo;

	// Window bounds in half-line ticks
	assign w50_lo  = FRAME50_HL - REG_WIN_HALF;
	assign w50_hi  = FRAME50_HL + REG_WIN_HALF;
	assign w60_lo  = FRAME60_HL - REG_WIN_HALF;
	assign w60_hi  = FRAME60_HL + REG_WIN_HALF;
	assign wide_lo = fsr_line_to_hl(WIDE_LO_LINE);

	// Register windows per standard
	assign in_w50 = fsr_in_range(pos_r, w50_lo, w50_hi);
	assign in_w60 = fsr_in_range(pos_r, w60_lo, w60_hi);

	// Sync window: wide unless identified, always wide in VCR mode
	always_comb begin
		if (vcr_mode) begin
			in_sync_win = fsr_in_range(pos_r, wide_lo, FREE_LONG_HL);
		end else if (fifty_hz_identified) begin
			in_sync_win = in_w50;
		end else if (sixty_hz_identified) begin
			in_sync_win = in_w60;
		end else begin
			in_sync_win = fsr_in_range(pos_r, wide_lo, FREE_LONG_HL);
		end
	end

	// Sync accepted only in window and with transmission present
	assign sync_accept = sync_pulse && transmission_present && in_sync_win;
	assign hit50       = sync_accept && in_w50;
	assign hit60       = sync_accept && in_w60;

	// Free-run limit per mode
	always_comb begin
		if (!transmission_present) begin
			free_limit = FRAME50_HL;
		end else if (sixty_hz_identified && !vcr_mode) begin
			free_limit = w60_hi;
		end else begin
			free_limit = FREE_LONG_HL;
		end
	end

	assign frame_end = sync_accept || (pos_r >= free_limit);

	// ==========================================================
	// Frame state next values
	always_comb begin
		pos_nxt    = pos_r;
		shr50_nxt  = shr50_r;
		shr60_nxt  = shr60_r;
		fifty_nxt  = fifty_hz_identified;
		sixty_nxt  = sixty_hz_identified;
		disch_nxt  = sawtooth_discharge;
		if (frame_end) begin
			pos_nxt   = '0;
			shr50_nxt = {shr50_r[0], hit50};
			shr60_nxt = {shr60_r[1:0], hit60};
			fifty_nxt = (shr50_r == 2'h3);
			if (shr60_nxt == 3'h7) begin
				sixty_nxt = 1'b1;
			end else if (shr60_nxt == 3'h0) begin
				sixty_nxt = 1'b0;
			end
			disch_nxt = 1'b1;
		end else if (tick) begin
			if (pos_r < FREE_LONG_HL) begin
				pos_nxt = pos_r + 10'h001;
			end
			if (pos_r >= DISCH_HL - 10'h001) begin
				disch_nxt = 1'b0;
			end
		end
		narrow_nxt = !vcr_mode && (fifty_nxt || sixty_nxt);
	end

	// Frame state registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pos_r               <= '0;
			shr50_r             <= SHR50_RST;
			shr60_r             <= SHR60_RST;
			fifty_hz_identified <= 1'b0;
			sixty_hz_identified <= 1'b0;
			slope_boost_enable  <= 1'b0;
			sawtooth_discharge  <= 1'b0;
			window_narrow       <= 1'b0;
		end else begin
			pos_r               <= pos_nxt;
			shr50_r             <= shr50_nxt;
			shr60_r             <= shr60_nxt;
			fifty_hz_identified <= fifty_nxt;
			sixty_hz_identified <= sixty_nxt;
			slope_boost_enable  <= sixty_nxt;
			sawtooth_discharge  <= disch_nxt;
			window_narrow       <= narrow_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_end;
		frame_end;
	endsequence

	sequence s_discharge_start;
		sawtooth_discharge && (pos_r == 10'h000);
	endsequence

	a_end_discharge: assert property (s_end |=> s_discharge_start)
		else $error("discharge not started at frame end");

	a_fifty_two_hits: assert property ($rose(fifty_hz_identified) |->
		$past(shr50_r) == 2'h3)
		else $error("50 Hz flag without two hits");

	a_fifty_stays_clear: assert property (frame_end && (shr50_r != 2'h3)
		|=> !fifty_hz_identified)
		else $error("50 Hz flag set without two hits");

	a_sixty_three_hits: assert property (frame_end && hit60
		&& (shr60_r[1:0] == 2'h3) |=> sixty_hz_identified)
		else $error("60 Hz not identified after three hits");

	a_sixty_needs_three: assert property ($rose(sixty_hz_identified) |->
		$past(shr60_r[1:0]) == 2'h3)
		else $error("60 Hz flag without three hits");

	a_boost_tracks: assert property (slope_boost_enable == sixty_hz_identified)
		else $error("slope boost differs from 60 Hz flag");

	a_mute_ignores: assert property (!transmission_present |-> !sync_accept)
		else $error("sync accepted without transmission");

	a_freerun_bound: assert property (pos_r <= FREE_LONG_HL)
		else $error("frame count ran past free-run limit");

	a_vcr_wide: assert property (vcr_mode && $past(vcr_mode) |-> !window_narrow)
		else $error("window narrowed in VCR mode");

	a_narrow_on_id: assert property ($past(!vcr_mode) && $past(!vcr_mode, 2)
		&& fifty_hz_identified |-> window_narrow)
		else $error("window not narrowed after identification");

	a_counter_reset: assert property (sync_accept |=> pos_r == 10'h000)
		else $error("counter not reset by accepted sync");

endmodule // fsr_frame_logic
`default_nettype wire

// file: fsr_sync_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Frame sync extractor model
module fsr_sync_model (
	input  wire logic clk_sys,   // System clock
	input  wire logic rst,       // Async reset, active high
	input  wire logic send_req,  // Request one frame sync
	output logic      sync_pulse // One clean clocked pulse
);
	logic req_r;

	// One registered pulse per request edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			req_r      <= 1'b0;
			sync_pulse <= 1'b0;
		end else begin
			req_r      <= send_req;
			sync_pulse <= send_req & ~req_r;
		end
	end
endmodule // fsr_sync_model
`default_nettype wire

// file: frame_standard_recognition_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Frame standard recognition testbench
module frame_standard_recognition_tb_top;
	import fsr_pkg::*;
	logic clk_sys, rst, send_req, sync_pulse, transmission_present, vcr_mode;
	logic disch, disch_d, fifty, sixty, boost, narrow;
	int   cyc, last_len, miscompares, total_checks;
	// Shortened half line keeps every frame to a few thousand clocks
	localparam int HL = 8;
	bit   seen;

	// Clock, 8 ns period
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	fsr_frame_logic #(.HALF_LINE_P(HL)) i_dut (.clk_sys(clk_sys), .rst(rst),
		.sync_pulse(sync_pulse),
		.transmission_present(transmission_present), .vcr_mode(vcr_mode),
		.sawtooth_discharge(disch), .fifty_hz_identified(fifty),
		.sixty_hz_identified(sixty), .slope_boost_enable(boost), .window_narrow(narrow));
	fsr_sync_model i_sync (.clk_sys(clk_sys), .rst(rst), .send_req(send_req),
		.sync_pulse(sync_pulse));

	// Cycles since the last discharge rise
	always @(posedge clk_sys) begin
		disch_d <= disch;
		if (rst) begin
			cyc <= 0;
		end else if (disch && !disch_d) begin
			last_len <= cyc;
			cyc      <= 1;
		end else begin
			cyc <= cyc + 1;
		end
	end

	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkn(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flags(input logic f, input logic s, input logic w);
		chk1(fifty, f);
		chk1(sixty, s);
		chk1(boost, s);
		chk1(narrow, w);
	endtask

	// Wait a bounded time for a frame end
	task automatic wait_end(input int lim);
		seen = 0;
		for (int i = 0; i < lim && !seen; i++) begin
			@(posedge clk_sys);
			#1 seen = (cyc == 1);
		end
	endtask

	// Sync in mid tick at position p, then see if the frame ends there
	task automatic frame_sync(input int p, input bit exp);
		while (cyc != p * HL + 2)
			@(posedge clk_sys);
		send_req <= 1'b1;
		@(posedge clk_sys);
		send_req <= 1'b0;
		wait_end(10);
		chk1(seen, exp);
		if (seen)
			chkn(last_len / HL, p);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog
	initial begin
		#600_000;
		miscompares++;
		end_sim();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		send_req = 1'b0;
		transmission_present = 1'b0;
		vcr_mode = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1 chk1(disch, 1'b0);
		chk_flags(1'b0, 1'b0, 1'b0);
		frame_sync(550, 1'b0);
		wait_end(80 * HL);
		chk1(seen, 1'b1);
		chkn(last_len / HL, 625);
		while (cyc != HL + 2)
			@(posedge clk_sys);
		#1 chk1(disch, 1'b1);
		while (cyc != 2 * HL - 1)
			@(posedge clk_sys);
		#1 chk1(disch, 1'b1);
		while (cyc != 2 * HL + 2)
			@(posedge clk_sys);
		#1 chk1(disch, 1'b0);
		@(posedge clk_sys);
		transmission_present <= 1'b1;
		frame_sync(100, 1'b0);
		frame_sync(625, 1'b1);
		frame_sync(625, 1'b1);
		chk_flags(1'b0, 1'b0, 1'b0);
		frame_sync(625, 1'b1);
		chk_flags(1'b1, 1'b0, 1'b1);
		frame_sync(560, 1'b0);
		frame_sync(625, 1'b1);
		@(posedge clk_sys);
		vcr_mode <= 1'b1;
		frame_sync(521, 1'b1);
		frame_sync(521, 1'b1);
		chk_flags(1'b0, 1'b0, 1'b0);
		frame_sync(521, 1'b1);
		chk_flags(1'b0, 1'b1, 1'b0);
		@(posedge clk_sys);
		vcr_mode <= 1'b0;
		wait_end(530 * HL);
		chkn(last_len / HL, 527);
		chk_flags(1'b0, 1'b1, 1'b1);
		end_sim();
	end
endmodule // frame_standard_recognition_tb_top
`default_nettype wire
